// ---- include/itfm_pkg.sv ----
// constants and types for the four-mode interval timer
package itfm_pkg;

    localparam int          ITFM_CNT_W     = 14;
    localparam logic [13:0] ITFM_COUNT_RST = 14'h0000;
    localparam logic [13:0] ITFM_LEN_RST   = 14'h0002;
    localparam logic [13:0] ITFM_MIN_LEN   = 14'h0002;
    localparam logic [13:0] ITFM_TC_VALUE  = 14'h0001;
    localparam int          ITFM_SYNC_DEPTH = 2;

    typedef enum logic [1:0] {
        ITFM_HALF_SINGLE,
        ITFM_SQUARE_RELOAD,
        ITFM_SINGLE_PULSE,
        ITFM_REPEATING_DIVIDER
    } itfm_mode_e;

    localparam itfm_mode_e ITFM_MODE_RST = ITFM_HALF_SINGLE;

endpackage

// ---- include/itfm_tick_if.sv ----
// carrier for the synchronised timer-clock edge between the timer's own modules
`timescale 1ns/1ps
interface itfm_tick_if;
    logic tick;

    modport src
    (
        output tick
    );

    modport dst
    (
        input  tick
    );
endinterface

// ---- rtl/itfm_edge_sync.sv ----
// two-stage synchroniser and rising-edge detector for the timer input clock
`timescale 1ns/1ps
module itfm_edge_sync
    import itfm_pkg::*;
(
    input  wire logic   clk_sys_in,
    input  wire logic   rst_in,
    input  wire logic   pin_in,
    itfm_tick_if.src    tick_if
);

    logic meta_ff;
    logic sync_ff;
    logic last_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // meta_ff is read only by sync_ff
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
        end
        else
        begin
            meta_ff <= pin_in;
            sync_ff <= meta_ff;
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            last_ff <= 1'b0;
        end
        else
        begin
            last_ff <= sync_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    assign tick_if.tick  = sync_ff & ~last_ff;

endmodule

// ---- rtl/itfm_timer.sv ----
// four-mode 14-bit interval timer, top level
`timescale 1ns/1ps
module itfm_timer
    import itfm_pkg::*;
#(
    parameter int CNT_W = ITFM_CNT_W
)
(
    input  wire logic               clk_sys_in,
    input  wire logic               rst_in,
    input  wire logic               timer_clk_in,
    input  wire logic               load_in,
    input  wire logic [CNT_W-1:0]   length_in,
    input  wire logic [1:0]         mode_in,
    input  wire logic               stop_in,
    input  wire logic               irq_clr_in,
    output logic      [CNT_W-1:0]   count_out,
    output logic      [1:0]         mode_out,
    output logic      [CNT_W-1:0]   length_out,
    output logic                    running_out,
    output logic                    timer_out_out,
    output logic                    tc_out,
    output logic                    irq_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    if (CNT_W != ITFM_CNT_W)
    begin : g_width_check
        $error("itfm_timer: CNT_W must equal the 14-bit count length");
    end

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    itfm_tick_if tick_bus ();

    logic [CNT_W-1:0]   count_ff;
    logic [CNT_W-1:0]   nxt_count;
    logic [CNT_W-1:0]   length_ff;
    logic [CNT_W-1:0]   half_len;
    logic [CNT_W-1:0]   load_len;
    itfm_mode_e         mode_ff;
    itfm_mode_e         load_mode;
    logic               running_ff;
    logic               nxt_running;
    logic               out_ff;
    logic               nxt_out;
    logic               tc_ff;
    logic               irq_ff;
    logic               at_final;
    logic               tc_event;
    logic               reload_mode;
    logic               done_event;

    ////////////////////////////////////////////////////////////////////////////////
    // timer clock crossing
    itfm_edge_sync u_edge_sync
    (
        .clk_sys_in (clk_sys_in),
        .rst_in     (rst_in),
        .pin_in     (timer_clk_in),
        .tick_if    (tick_bus.src)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // load decode
    // lengths below two cannot form two halves, so they are raised to two
    assign load_len  = (length_in < ITFM_MIN_LEN) ? ITFM_MIN_LEN : length_in;
    assign load_mode = itfm_mode_e'(mode_in);
    assign half_len  = length_ff >> 1;

    assign at_final    = (count_ff == ITFM_TC_VALUE);
    assign tc_event    = running_ff & tick_bus.tick & at_final;
    assign reload_mode = (mode_ff == ITFM_SQUARE_RELOAD) ||
                         (mode_ff == ITFM_REPEATING_DIVIDER);
    // single-shot modes complete once, reloading modes complete every period
    assign done_event  = tc_event;

    ////////////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            length_ff <= ITFM_LEN_RST;
            mode_ff   <= ITFM_MODE_RST;
        end
        else if (load_in)
        begin
            length_ff <= load_len;
            mode_ff   <= load_mode;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // counter and run state
    always_comb
    begin
        nxt_count   = count_ff;
        nxt_running = running_ff;
        if (load_in)
        begin
            nxt_count   = load_len;
            nxt_running = 1'b1;
        end
        else if (stop_in)
        begin
            nxt_running = 1'b0;
        end
        else if (running_ff && tick_bus.tick)
        begin
            if (at_final)
            begin
                if (reload_mode)
                begin
                    nxt_count = length_ff;
                end
                else
                begin
                    nxt_count   = ITFM_COUNT_RST;
                    nxt_running = 1'b0;
                end
            end
            else
            begin
                nxt_count = count_ff - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_ff   <= ITFM_COUNT_RST;
            running_ff <= 1'b0;
        end
        else
        begin
            count_ff   <= nxt_count;
            running_ff <= nxt_running;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // output waveform, decided from the next count so it tracks it exactly
    always_comb
    begin
        nxt_out = 1'b1;
        if (nxt_running)
        begin
            unique case (load_in ? load_mode : mode_ff)
                ITFM_HALF_SINGLE:
                begin
                    nxt_out = ~(nxt_count <= (load_in ? (load_len >> 1) : half_len));
                end
                ITFM_SQUARE_RELOAD:
                begin
                    nxt_out = ~(nxt_count <= (load_in ? (load_len >> 1) : half_len));
                end
                ITFM_SINGLE_PULSE:
                begin
                    nxt_out = (nxt_count != ITFM_TC_VALUE);
                end
                ITFM_REPEATING_DIVIDER:
                begin
                    nxt_out = (nxt_count != ITFM_TC_VALUE);
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_ff <= 1'b1;
        end
        else
        begin
            out_ff <= nxt_out;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // terminal count pulse
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            tc_ff <= 1'b0;
        end
        else
        begin
            tc_ff <= tc_event;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt request, set wins over clear
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            irq_ff <= 1'b0;
        end
        else if (done_event)
        begin
            irq_ff <= 1'b1;
        end
        else if (irq_clr_in)
        begin
            irq_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back is straight from the state registers
    assign count_out     = count_ff;
    assign mode_out      = mode_ff;
    assign length_out    = length_ff;
    assign running_out   = running_ff;
    assign timer_out_out = out_ff;
    assign tc_out        = tc_ff;
    assign irq_out       = irq_ff;

endmodule

// ---- sim/itfm_timer_asserts.sv ----
// port assertions for the four-mode timer
`timescale 1ns/1ps
module itfm_timer_asserts
    import itfm_pkg::*;
#(
    parameter int CNT_W = ITFM_CNT_W
)
(
    input wire logic             clk_sys_in,
    input wire logic             rst_in,
    input wire logic             load_in,
    input wire logic [CNT_W-1:0] length_in,
    input wire logic [1:0]       mode_in,
    input wire logic             stop_in,
    input wire logic [CNT_W-1:0] count_out,
    input wire logic [1:0]       mode_out,
    input wire logic [CNT_W-1:0] length_out,
    input wire logic             running_out,
    input wire logic             timer_out_out,
    input wire logic             tc_out,
    input wire logic             irq_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    // last step of a reloading count
    sequence s_final_tick;
        running_out && mode_out[0] && count_out == ITFM_TC_VALUE && !load_in && !stop_in
            ##1 count_out != ITFM_TC_VALUE;
    endsequence
    chk_load_count: assert property (load_in |=> running_out && count_out ==
        ($past(length_in) < ITFM_MIN_LEN ? ITFM_MIN_LEN : $past(length_in)))
        else $error("load did not start the count");
    chk_load_mode: assert property (load_in |=> mode_out == $past(mode_in))
        else $error("mode not taken at load");
    chk_count_step: assert property ($past(running_out) && !$past(load_in)
        && $changed(count_out) |-> count_out == $past(count_out) - 1'b1
        || count_out == length_out) else $error("count moved by other than one");
    chk_idle_high: assert property (!running_out && !$past(running_out) |-> timer_out_out)
        else $error("output low while idle");
    chk_half_out: assert property (running_out && !mode_out[1] |->
        timer_out_out == (count_out > (length_out >> 1))) else $error("half output wrong");
    chk_pulse_out: assert property (running_out && mode_out[1] |->
        timer_out_out == (count_out != ITFM_TC_VALUE)) else $error("pulse output wrong");
    chk_done_irq: assert property ($fell(running_out) && !$past(stop_in) |-> irq_out)
        else $error("completion without interrupt");
    chk_reload_len: assert property (s_final_tick |-> count_out == length_out && running_out)
        else $error("no reload at terminal count");
    chk_tc_once: assert property (tc_out |=> !tc_out)
        else $error("terminal pulse too long");
endmodule
bind itfm_timer itfm_timer_asserts #(.CNT_W(CNT_W)) u_asserts
(
    .clk_sys_in(clk_sys_in), .rst_in(rst_in), .load_in(load_in), .length_in(length_in),
    .mode_in(mode_in), .stop_in(stop_in), .count_out(count_out), .mode_out(mode_out),
    .length_out(length_out), .running_out(running_out), .timer_out_out(timer_out_out),
    .tc_out(tc_out), .irq_out(irq_out)
);

// ---- sim/test_itfm_timer.sv ----
// self-checking bench for the four-mode timer
`timescale 1ns/1ps
module test_itfm_timer;
    typedef struct {logic [1:0] m; logic [13:0] len; int n; logic [13:0] cnt;
        logic out; logic run; logic irq;} itfm_row_s;
    logic clk_sys_in = 0, rst_in = 1, timer_clk_in = 0, load_in = 0, stop_in = 0;
    logic irq_clr_in = 0, running_out, timer_out_out, tc_out, irq_out;
    logic [13:0] length_in = 0, count_out, length_out, tc_n = 0;
    logic [1:0] mode_in = 0, mode_out;
    int n_errors = 0, compares = 0;
    itfm_row_s rows [10] = '{'{0,4,2,2,0,1,0}, '{0,4,4,0,1,0,1}, '{1,4,1,3,1,1,0},
        '{1,4,4,4,1,1,1}, '{1,5,2,3,1,1,0}, '{1,5,3,2,0,1,0}, '{2,3,2,1,0,1,0},
        '{2,3,3,0,1,0,1}, '{3,3,3,3,1,1,1}, '{0,1,0,2,1,1,0}};
    itfm_timer DUT
    (
        .clk_sys_in(clk_sys_in), .rst_in(rst_in), .timer_clk_in(timer_clk_in),
        .load_in(load_in), .length_in(length_in), .mode_in(mode_in), .stop_in(stop_in),
        .irq_clr_in(irq_clr_in), .count_out(count_out), .mode_out(mode_out),
        .length_out(length_out), .running_out(running_out), .timer_out_out(timer_out_out),
        .tc_out(tc_out), .irq_out(irq_out)
    );
    initial forever #12.5 clk_sys_in = ~clk_sys_in;
    always @(negedge clk_sys_in) if (tc_out === 1'b1) tc_n++;
    ////////////////////////////////////////
    task automatic check(input logic [13:0] got, input logic [13:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n)
        begin
            timer_clk_in = 1;
            repeat (4) @(negedge clk_sys_in);
            timer_clk_in = 0;
            repeat (4) @(negedge clk_sys_in);
        end
    endtask
    task automatic pulse(ref logic s);
        s = 1;
        @(negedge clk_sys_in);
        s = 0;
    endtask
    task automatic start(input logic [1:0] m, input logic [13:0] len);
        pulse(irq_clr_in);
        mode_in = m;
        length_in = len;
        pulse(load_in);
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        n_errors++;
        print_verdict;
    end
    ////////////////////////////////////////
    initial
    begin
        repeat (8) @(negedge clk_sys_in);
        rst_in = 0;
        @(negedge clk_sys_in);
        foreach (rows[i])
        begin
            start(rows[i].m, rows[i].len);
            tick(rows[i].n);
            check(count_out, rows[i].cnt);
            check(mode_out, rows[i].m);
            check(timer_out_out, rows[i].out);
            check(running_out, rows[i].run);
            check(irq_out, rows[i].irq);
            check(length_out, (rows[i].len < 14'h0002) ? 14'h0002 : rows[i].len);
        end
        // a finished single pulse stays quiet
        start(2, 2);
        tick(2);
        pulse(irq_clr_in);
        tick(3);
        check(count_out, 0);
        check(timer_out_out, 1);
        check(irq_out, 0);
        // divider pulses twice, then stop holds the count
        tc_n = 0;
        start(3, 2);
        tick(5);
        check(tc_n, 2);
        check(count_out, 1);
        pulse(stop_in);
        tick(2);
        check(count_out, 1);
        check(running_out, 0);
        // back-to-back loads, the second wins
        mode_in = 1;
        length_in = 6;
        load_in = 1;
        @(negedge clk_sys_in);
        mode_in = 2;
        length_in = 7;
        pulse(load_in);
        check(count_out, 7);
        check(mode_out, 2);
        check(length_out, 7);
        // reset in mid-count
        tick(1);
        check(count_out, 6);
        pulse(rst_in);
        check(count_out, 0);
        check(mode_out, 0);
        check(length_out, 2);
        check(timer_out_out, 1);
        check(irq_out, 0);
        print_verdict;
    end
endmodule
